/* rtl/lsbc_defs.vh */
`ifndef LSBC_DEFS_VH
`define LSBC_DEFS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LSBC_OFS_LS_PROTECT   8'h15
`define LSBC_OFS_BUCK_ONE     8'h16
`define LSBC_OFS_GO_CTRL      8'h1A
// ----------------------------------------
// Reset values
// ----------------------------------------
`define LSBC_RST_LS_PROTECT   8'h00
`define LSBC_RST_BUCK_ONE     8'hAB
`define LSBC_RST_VSEL         6'h2B
`define LSBC_RST_PSKIP        1'b1
// ----------------------------------------
// Field positions
// ----------------------------------------
`define LSBC_BIT_PF_OFF_LO    3
`define LSBC_BIT_DCHG_LO      0
`define LSBC_BIT_PSKIP        7
`define LSBC_VSEL_HI          5
`define LSBC_BIT_GO           0
`define LSBC_BIT_GO_NOMON     1
`define LSBC_LS_WMASK         8'h3F
`define LSBC_BUCK_WMASK       8'hBF
// ----------------------------------------
// Timing
// ----------------------------------------
`define LSBC_BLANK_MS         5
`define LSBC_CLK_HZ           20000000
`define LSBC_BLANK_CYC        (`LSBC_BLANK_MS * (`LSBC_CLK_HZ / 1000))
`endif

/* rtl/lsbc_switch_ctrl.v */
`timescale 1ns/1ns
`default_nettype none
module lsbc_switch_ctrl (
	// Clock and reset
	input  wire ref_clk,
	input  wire arst_n,
	// Control
	input  wire sw_enable,
	input  wire pf_off_en,
	input  wire dchg_en,
	input  wire pf_ok,
	// Outputs
	output reg  sw_on_q,
	output reg  dchg_q
);
	wire on_d;

	// Power-fail low forces the switch off only when armed
	assign on_d = sw_enable & ~(pf_off_en & ~pf_ok);

	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sw_on_q <= 1'b0;
			dchg_q  <= 1'b0;
		end else begin
			sw_on_q <= on_d;
			dchg_q  <= dchg_en & ~on_d;
		end
	end
endmodule
`default_nettype wire

/* rtl/lsbc_regs.v */
// Operation
// - Protect config at 0x15, resets zero
// - Protected registers need unlock valid in the same cycle as each write
// - Armed power-fail bit turns switch off
// - Unarmed bit ignores power-fail comparator
// - Discharge enabled drives discharge when off
// - Discharge disabled never drives discharge
// - Buck register at 0x16, resets 0xAB
// - Buck write blanks voltage monitoring 5 ms
// - New voltage applies only after go bit
// - Bit 7 pulse-skip enable, resets one
// - Bits 5-0 voltage code, resets 2Bh
`timescale 1ns/1ns
`default_nettype none
`include "lsbc_defs.vh"
module lsbc_regs #(
	parameter BLANK_CYC = `LSBC_BLANK_CYC
) (
	// Clock and reset
	input  wire       ref_clk,
	input  wire       arst_n,
	// Register port from serial bus engine
	input  wire       reg_wr,
	input  wire       reg_rd,
	input  wire [7:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       unlock_valid,
	output reg  [7:0] reg_rdata_q,
	output reg        wr_reject_q,
	// Analog side
	input  wire       power_fail_comparator_out,
	input  wire [2:0] switch_enable,
	output wire [2:0] switch_on_q,
	output wire [2:0] switch_discharge_q,
	output reg        pulse_skip_enable_q,
	output reg  [5:0] buck_one_vsel_q,
	output reg        monitor_blank_q,
	output reg        monitor_disable_q
);
	// ----------------------------------------
	// Pin synchroniser
	// ----------------------------------------
	reg pf_meta_q;
	reg pf_sync_q;

	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pf_meta_q <= 1'b1;
			pf_sync_q <= 1'b1;
		end else begin
			pf_meta_q <= power_fail_comparator_out;
			pf_sync_q <= pf_meta_q;
		end
	end

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	reg  [7:0] ls_cfg_q;
	reg  [7:0] buck_q;
	wire       hit_ls;
	wire       hit_buck;
	wire       hit_go;
	wire       wr_ok;
	wire       go_now;

	assign hit_ls   = (reg_addr == `LSBC_OFS_LS_PROTECT);
	assign hit_buck = (reg_addr == `LSBC_OFS_BUCK_ONE);
	assign hit_go   = (reg_addr == `LSBC_OFS_GO_CTRL);
	// Unlock is sampled on the write cycle itself
	assign wr_ok    = reg_wr & unlock_valid;
	assign go_now   = reg_wr & hit_go &
	                  (reg_wdata[`LSBC_BIT_GO] | reg_wdata[`LSBC_BIT_GO_NOMON]);

	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ls_cfg_q    <= `LSBC_RST_LS_PROTECT;
			buck_q      <= `LSBC_RST_BUCK_ONE;
			wr_reject_q <= 1'b0;
		end else begin
			wr_reject_q <= reg_wr & (hit_ls | hit_buck) & ~unlock_valid;
			if (wr_ok && hit_ls)
				ls_cfg_q <= reg_wdata & `LSBC_LS_WMASK;
			if (wr_ok && hit_buck)
				buck_q <= reg_wdata & `LSBC_BUCK_WMASK;
		end
	end

	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata_q <= 8'h00;
		end else if (reg_rd) begin
			if (hit_ls)
				reg_rdata_q <= ls_cfg_q;
			else if (hit_buck)
				reg_rdata_q <= buck_q;
			else
				reg_rdata_q <= 8'h00;
		end
	end

	// ----------------------------------------
	// Buck converter setpoint
	// ----------------------------------------
	// Mode bit acts at once; only the voltage waits for the go strobe
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pulse_skip_enable_q <= `LSBC_RST_PSKIP;
			buck_one_vsel_q     <= `LSBC_RST_VSEL;
			monitor_disable_q   <= 1'b0;
		end else begin
			pulse_skip_enable_q <= buck_q[`LSBC_BIT_PSKIP];
			if (go_now) begin
				buck_one_vsel_q   <= buck_q[`LSBC_VSEL_HI:0];
				monitor_disable_q <= reg_wdata[`LSBC_BIT_GO_NOMON];
			end
		end
	end

	// ----------------------------------------
	// Monitoring blank timer
	// ----------------------------------------
	reg [23:0] blank_cnt_q;

	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			blank_cnt_q     <= 24'h000000;
			monitor_blank_q <= 1'b0;
		end else if (wr_ok && hit_buck) begin
			// A fresh write restarts the full interval
			blank_cnt_q     <= BLANK_CYC[23:0] - 24'h000001;
			monitor_blank_q <= 1'b1;
		end else if (blank_cnt_q != 24'h000000) begin
			blank_cnt_q     <= blank_cnt_q - 24'h000001;
			monitor_blank_q <= 1'b1;
		end else begin
			monitor_blank_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// Load switches
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < 3; i = i + 1) begin : g_sw
			lsbc_switch_ctrl u_sw (
				.ref_clk   (ref_clk),
				.arst_n    (arst_n),
				.sw_enable (switch_enable[i]),
				.pf_off_en (ls_cfg_q[`LSBC_BIT_PF_OFF_LO + i]),
				.dchg_en   (ls_cfg_q[`LSBC_BIT_DCHG_LO + i]),
				.pf_ok     (pf_sync_q),
				.sw_on_q   (switch_on_q[i]),
				.dchg_q    (switch_discharge_q[i])
			);
		end
	endgenerate
endmodule
`default_nettype wire

/* tb/lsbc_regs_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module lsbc_regs_chk (
	// Clock, reset and register port
	input wire       ref_clk,
	input wire       arst_n,
	input wire       reg_wr,
	input wire       reg_rd,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire       unlock_valid,
	// Outputs
	input wire [7:0] reg_rdata_q,
	input wire       wr_reject_q,
	input wire [2:0] switch_on_q,
	input wire [2:0] switch_discharge_q,
	input wire [5:0] buck_one_vsel_q,
	input wire       monitor_blank_q,
	input wire       monitor_disable_q
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	wire w16 = reg_wr && reg_addr == 8'h16;
	AST_LOCKED: assert property (reg_wr && reg_addr == 8'h15 && !unlock_valid |=> wr_reject_q)
		else $error("locked write not refused");
	AST_UNLOCKED: assert property (reg_wr && unlock_valid |=> !wr_reject_q)
		else $error("unlocked write refused");
	AST_BLANK: assert property (w16 && unlock_valid |=> monitor_blank_q [*3])
		else $error("no blanking after buck write");
	// A go write just before has already moved the code by the first sample
	AST_HOLD: assert property (w16 && !$past(reg_wr) |=> $stable(buck_one_vsel_q))
		else $error("voltage code moved without go");
	AST_EXCL: assert property ((switch_on_q & switch_discharge_q) == 3'h0)
		else $error("discharge while switch on");
	AST_RST: assert property ($rose(arst_n) |-> buck_one_vsel_q == 6'h2B)
		else $error("voltage code reset wrong");
	AST_RES: assert property (reg_rd && reg_addr == 8'h16 |=> !reg_rdata_q[6])
		else $error("reserved bit reads one");
	AST_NOMON: assert property (reg_wr && reg_addr == 8'h1A && reg_wdata[1] |=> monitor_disable_q)
		else $error("monitor not disabled");
endmodule
bind lsbc_regs lsbc_regs_chk u_chk (.ref_clk, .arst_n, .reg_wr, .reg_rd, .reg_addr,
	.reg_wdata, .unlock_valid, .reg_rdata_q, .wr_reject_q, .switch_on_q,
	.switch_discharge_q, .buck_one_vsel_q, .monitor_blank_q, .monitor_disable_q);
`default_nettype wire

/* tb/lsbc_host.sv */
`timescale 1ns/1ns
`default_nettype none
module lsbc_host (
	// Clock
	input  wire        ref_clk,
	// Register port
	output logic       reg_wr = 1'b0,
	output logic       reg_rd = 1'b0,
	output logic [7:0] reg_addr = 8'h00,
	output logic [7:0] reg_wdata = 8'h00,
	output logic       unlock_valid = 1'b0,
	input  wire  [7:0] reg_rdata_q
);
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic u);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		unlock_valid <= u;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		unlock_valid <= 1'b0;
		// Released data is scrambled so stale values cannot pass
		reg_wdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1 q = reg_rdata_q;
	endtask
endmodule
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic power_fail_comparator_out = 1'b1;
	logic [2:0] switch_enable = 3'h0;
	wire reg_wr, reg_rd, unlock_valid, wr_reject_q, pulse_skip_enable_q;
	wire monitor_blank_q, monitor_disable_q;
	wire [7:0] reg_addr, reg_wdata, reg_rdata_q;
	wire [2:0] switch_on_q, switch_discharge_q;
	wire [5:0] buck_one_vsel_q;
	int mismatches = 0;
	int check_count = 0;
	logic [31:0] seed = 32'h0000BDEE;
	logic [7:0] q, c;
	always #25 ref_clk = ~ref_clk;
	lsbc_host u_host (.ref_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .unlock_valid,
		.reg_rdata_q);
	lsbc_regs #(.BLANK_CYC(20)) DUT (.ref_clk, .arst_n, .reg_wr, .reg_rd, .reg_addr,
		.reg_wdata, .unlock_valid, .reg_rdata_q, .wr_reject_q, .power_fail_comparator_out,
		.switch_enable, .switch_on_q, .switch_discharge_q, .pulse_skip_enable_q,
		.buck_one_vsel_q, .monitor_blank_q, .monitor_disable_q);
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [7:0] exp_sw(logic [7:0] cfg, logic [2:0] en, logic pf);
		logic [2:0] on;
		on = en & ~(cfg[5:3] & {3{~pf}});
		return {2'h0, on, cfg[2:0] & ~on};
	endfunction
	task automatic chk(string n, logic [7:0] s, logic [7:0] e);
		check_count++;
		if (s !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic end_sim();
		if (mismatches == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#2000000;
		mismatches++;
		end_sim();
	end
	initial begin
		repeat (12) @(posedge ref_clk);
		arst_n <= 1'b1;
		u_host.rd(8'h15, q);
		chk("ls_rst", q, 8'h00);
		u_host.rd(8'h16, q);
		chk("buck_rst", q, 8'hAB);
		chk("vsel_rst", 8'(buck_one_vsel_q), 8'h2B);
		chk("pskip_rst", 8'(pulse_skip_enable_q), 8'h01);
		u_host.wr(8'h15, 8'h3F, 1'b0);
		#1 chk("reject", 8'(wr_reject_q), 8'h01);
		u_host.rd(8'h15, q);
		chk("locked", q, 8'h00);
		for (int i = 0; i < 10; i++) begin
			c = (i == 0) ? 8'hFF : 8'(rnd());
			u_host.wr(8'h15, c, 1'b1);
			u_host.rd(8'h15, q);
			chk("ls_rb", q, c & 8'h3F);
			@(posedge ref_clk);
			switch_enable <= (i == 0) ? 3'h7 : 3'(rnd());
			power_fail_comparator_out <= (i == 0) ? 1'b0 : 1'(rnd());
			repeat (5) @(posedge ref_clk);
			#1 chk("sw", {2'h0, switch_on_q, switch_discharge_q}, exp_sw(c, switch_enable, power_fail_comparator_out));
		end
		c = 8'(rnd());
		u_host.wr(8'h16, c, 1'b1);
		#1 chk("blank", 8'(monitor_blank_q), 8'h01);
		chk("hold", 8'(buck_one_vsel_q), 8'h2B);
		u_host.rd(8'h16, q);
		chk("buck_rb", q, c & 8'hBF);
		repeat (20) @(posedge ref_clk);
		#1 chk("unblank", 8'(monitor_blank_q), 8'h00);
		u_host.wr(8'h1A, 8'h02, 1'b0);
		#1 chk("apply", {2'h0, buck_one_vsel_q}, {2'h0, c[5:0]});
		chk("mdis", 8'(monitor_disable_q), 8'h01);
		chk("pskip", 8'(pulse_skip_enable_q), 8'(c[7]));
		u_host.wr(8'h1A, 8'h01, 1'b0);
		#1 chk("mdis_clr", 8'(monitor_disable_q), 8'h00);
		c = 8'(rnd());
		u_host.wr(8'h16, c, 1'b1);
		u_host.wr(8'h1A, 8'h01, 1'b0);
		#1 chk("apply_go", {2'h0, buck_one_vsel_q}, {2'h0, c[5:0]});
		u_host.rd(8'h1A, q);
		chk("unmapped", q, 8'h00);
		end_sim();
	end
endmodule
`default_nettype wire
